// *** logic/hpscc_pkg.sv ***
// constants and encodings shared by the hot-plug slot capability/control register block
`default_nettype none

package hpscc_pkg;

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] OFS_SLOT_CAP = 8'h7C;
  localparam logic [7:0] OFS_SLOT_STS_CTL = 8'h80;

  // ---------------------------------------------------------------
  // slot capability field positions
  // ---------------------------------------------------------------
  localparam int unsigned CAP_FEAT_LSB = 0;
  localparam int unsigned CAP_FEAT_MSB = 3;
  localparam int unsigned CAP_PWR_IND_PRES = 4;
  localparam int unsigned CAP_SURPRISE = 5;
  localparam int unsigned CAP_HP_CAPABLE = 6;
  localparam int unsigned CAP_LIMIT_LSB = 7;
  localparam int unsigned CAP_LIMIT_MSB = 14;
  localparam int unsigned CAP_SCALE_LSB = 15;
  localparam int unsigned CAP_SCALE_MSB = 16;
  localparam int unsigned CAP_SLOT_LSB = 19;
  localparam int unsigned CAP_SLOT_MSB = 31;

  // ---------------------------------------------------------------
  // slot control and status field positions
  // ---------------------------------------------------------------
  localparam int unsigned NUM_EVT = 5;
  localparam int unsigned CTL_EN_LSB = 0;
  localparam int unsigned CTL_MASTER_EN = 5;
  localparam int unsigned CTL_ATTN_LSB = 6;
  localparam int unsigned CTL_ATTN_MSB = 7;
  localparam int unsigned STS_FLAG_LSB = 16;
  localparam int unsigned STS_LATCH_STATE = 21;
  localparam int unsigned STS_PRESENCE_STATE = 22;

  // event and synchroniser indices
  localparam int unsigned EVT_BUTTON = 0;
  localparam int unsigned EVT_PWR_FAULT = 1;
  localparam int unsigned EVT_LATCH_CHG = 2;
  localparam int unsigned EVT_PRESENCE_CHG = 3;
  localparam int unsigned EVT_CMD_DONE = 4;
  localparam int unsigned SYNC_MODE = 5;
  localparam int unsigned NUM_SYNC = 6;

  // ---------------------------------------------------------------
  // reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [3:0] FEAT_RST = 4'h0;
  localparam logic [7:0] LIMIT_RST = 8'h19;
  localparam logic [7:0] LIMIT_FWD = 8'h00;
  localparam logic [1:0] SCALE_RST = 2'h0;
  localparam logic [12:0] SLOT_NUM_RST = 13'h0000;
  localparam logic [4:0] EVT_EN_RST = 5'h00;

  localparam logic [1:0] SCALE_X1_0 = 2'h0;
  localparam logic [1:0] SCALE_X0_1 = 2'h1;
  localparam logic [1:0] SCALE_X0_01 = 2'h2;
  localparam logic [1:0] SCALE_X0_001 = 2'h3;

  localparam logic [1:0] ATTN_RESERVED = 2'h0;
  localparam logic [1:0] ATTN_ON = 2'h1;
  localparam logic [1:0] ATTN_BLINK = 2'h2;
  localparam logic [1:0] ATTN_OFF = 2'h3;
  localparam logic [1:0] ATTN_RST = ATTN_OFF;

endpackage

`default_nettype wire

// *** logic/hpscc_sync.sv ***
// two-flop synchroniser for one slot pin, with edge and change detect
`default_nettype none

module hpscc_sync
  import hpscc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic async_i,
  output logic level_o,
  output logic rise_o,
  output logic change_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } hpscc_sync_state_t;

  hpscc_sync_state_t st_q;
  hpscc_sync_state_t st_d;

  always_comb
  begin
    st_d.s1 = async_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // s1 feeds only s2; detection looks at s2 and s3
  assign level_o = st_q.s2;
  assign rise_o = st_q.s2 & ~st_q.s3;
  assign change_o = st_q.s2 ^ st_q.s3;

endmodule

`default_nettype wire

// *** logic/hpscc_flag.sv ***
// sticky status flag, set by hardware, cleared by a write of one
`default_nettype none

module hpscc_flag
  import hpscc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);

  typedef struct packed {
    logic flag;
  } hpscc_flag_state_t;

  hpscc_flag_state_t st_q;
  hpscc_flag_state_t st_d;

  // set wins over a clear in the same cycle, so no event is lost
  always_comb
  begin
    st_d.flag = set_i | (st_q.flag & ~clr_i);
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign flag_o = st_q.flag;

endmodule

`default_nettype wire

// *** logic/hpscc_top.sv ***
// hot-plug slot capability, control and status registers of the reverse-mode port
`default_nettype none

//
// Function
// - capability bit 4 reports whether a power indicator is fitted
// - capability bit 5 reports whether surprise removal is allowed
// - capability bit 6 reports whether the slot is hot-plug capable
// - power limit value in bits 14:7, default 19h, scaled by bits 16:15
// - power limit scale in bits 16:15, four decimal multipliers, default 00b
// - physical slot number in bits 31:19, loaded at init, resets to zero
// - forward mode: all fields read-only and meaningless, power limit 00h
// - control bit 0 enables attention button event as interrupt source
// - control bit 1 enables power fault event as interrupt source
// - control bit 2 enables retention latch change as interrupt source
// - control bit 3 enables presence detect change as interrupt source
// - control bit 4 enables command completed as interrupt source
// - control bit 5 is master enable for all hot-plug interrupts
// - attention indicator bits 7:6: on, blink, off; resets to off
// - a write of 00b to the attention field is ignored
// - each accepted attention write sends an indicator message
// - reading the attention field returns the last accepted attention state
// - status bit 16 sets on button press, cleared by writing one
// - status bit 20 sets on command completion, cleared by writing one
module hpscc_top
  import hpscc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic reverse_mode_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  input wire logic load_cap_valid_i,
  input wire logic [DATA_W-1:0] load_cap_i,
  input wire logic attn_button_i,
  input wire logic power_fault_i,
  input wire logic latch_open_i,
  input wire logic presence_i,
  input wire logic cmd_done_i,
  output logic attn_msg_valid_o,
  output logic [1:0] attn_msg_code_o,
  output logic [1:0] attn_state_o,
  output logic hp_irq_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] feat_present;
    logic pwr_ind_present;
    logic surprise;
    logic hp_capable;
    logic [7:0] pwr_limit;
    logic [1:0] pwr_scale;
    logic [12:0] slot_num;
    logic [NUM_EVT-1:0] evt_en;
    logic master_en;
    logic [1:0] attn_state;
    logic attn_msg_valid;
    logic [1:0] attn_msg_code;
    logic hp_irq;
    logic [DATA_W-1:0] rdata;
  } hpscc_top_state_t;

  hpscc_top_state_t st_q;
  hpscc_top_state_t st_d;

  logic [NUM_SYNC-1:0] pin_raw;
  logic [NUM_SYNC-1:0] pin_lvl;
  logic [NUM_SYNC-1:0] pin_rise;
  logic [NUM_SYNC-1:0] pin_chg;
  logic [NUM_EVT-1:0] evt_pulse;
  logic [NUM_EVT-1:0] evt_set;
  logic [NUM_EVT-1:0] evt_clr;
  logic [NUM_EVT-1:0] flag;
  logic [NUM_EVT-1:0] evt_hit;
  logic rev_mode;
  logic sel_cap;
  logic sel_ctl;
  logic wr_ctl;
  logic attn_accept;
  logic [DATA_W-1:0] cap_word;
  logic [DATA_W-1:0] ctl_word;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // the mode strap is synchronised too, so a late or bouncing strap
  // never reaches the decode logic as a metastable level
  assign pin_raw[EVT_BUTTON] = attn_button_i;
  assign pin_raw[EVT_PWR_FAULT] = power_fault_i;
  assign pin_raw[EVT_LATCH_CHG] = latch_open_i;
  assign pin_raw[EVT_PRESENCE_CHG] = presence_i;
  assign pin_raw[EVT_CMD_DONE] = cmd_done_i;
  assign pin_raw[SYNC_MODE] = reverse_mode_i;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SYNC; gi++)
    begin : g_sync
      hpscc_sync u_sync (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .async_i(pin_raw[gi]),
        .level_o(pin_lvl[gi]),
        .rise_o(pin_rise[gi]),
        .change_o(pin_chg[gi])
      );
    end
  endgenerate

  assign rev_mode = pin_lvl[SYNC_MODE];

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  // button, fault and command completion are edges; latch and presence
  // report any change of level
  assign evt_pulse[EVT_BUTTON] = pin_rise[EVT_BUTTON];
  assign evt_pulse[EVT_PWR_FAULT] = pin_rise[EVT_PWR_FAULT];
  assign evt_pulse[EVT_LATCH_CHG] = pin_chg[EVT_LATCH_CHG];
  assign evt_pulse[EVT_PRESENCE_CHG] = pin_chg[EVT_PRESENCE_CHG];
  assign evt_pulse[EVT_CMD_DONE] = pin_rise[EVT_CMD_DONE];

  assign sel_cap = (reg_addr_i == OFS_SLOT_CAP);
  assign sel_ctl = (reg_addr_i == OFS_SLOT_STS_CTL);
  assign wr_ctl = reg_wr_i && sel_ctl && rev_mode;
  assign attn_accept =
    wr_ctl && (reg_wdata_i[CTL_ATTN_MSB:CTL_ATTN_LSB] != ATTN_RESERVED);

  assign evt_set = evt_pulse & {NUM_EVT{rev_mode}};
  assign evt_clr = reg_wdata_i[STS_FLAG_LSB +: NUM_EVT] & {NUM_EVT{wr_ctl}};

  generate
    for (gi = 0; gi < NUM_EVT; gi++)
    begin : g_flag
      hpscc_flag u_flag (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .set_i(evt_set[gi]),
        .clr_i(evt_clr[gi]),
        .flag_o(flag[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // per-source interrupt gating
  // ---------------------------------------------------------------
  assign evt_hit[EVT_BUTTON] = flag[EVT_BUTTON] & st_q.evt_en[EVT_BUTTON];
  assign evt_hit[EVT_PWR_FAULT] = flag[EVT_PWR_FAULT] & st_q.evt_en[EVT_PWR_FAULT];
  assign evt_hit[EVT_LATCH_CHG] = flag[EVT_LATCH_CHG] & st_q.evt_en[EVT_LATCH_CHG];
  assign evt_hit[EVT_PRESENCE_CHG] =
    flag[EVT_PRESENCE_CHG] & st_q.evt_en[EVT_PRESENCE_CHG];
  assign evt_hit[EVT_CMD_DONE] = flag[EVT_CMD_DONE] & st_q.evt_en[EVT_CMD_DONE];

  // ---------------------------------------------------------------
  // read words
  // ---------------------------------------------------------------
  always_comb
  begin
    cap_word = '0;
    cap_word[CAP_FEAT_MSB:CAP_FEAT_LSB] = st_q.feat_present;
    cap_word[CAP_PWR_IND_PRES] = st_q.pwr_ind_present;
    cap_word[CAP_SURPRISE] = st_q.surprise;
    cap_word[CAP_HP_CAPABLE] = st_q.hp_capable;
    cap_word[CAP_LIMIT_MSB:CAP_LIMIT_LSB] = st_q.pwr_limit;
    cap_word[CAP_SCALE_MSB:CAP_SCALE_LSB] = st_q.pwr_scale;
    cap_word[CAP_SLOT_MSB:CAP_SLOT_LSB] = st_q.slot_num;
  end

  // power indicator and power controller control are not held here and read zero
  always_comb
  begin
    ctl_word = '0;
    ctl_word[CTL_EN_LSB +: NUM_EVT] = st_q.evt_en;
    ctl_word[CTL_MASTER_EN] = st_q.master_en;
    ctl_word[CTL_ATTN_MSB:CTL_ATTN_LSB] = st_q.attn_state;
    ctl_word[STS_FLAG_LSB +: NUM_EVT] = flag;
    ctl_word[STS_LATCH_STATE] = pin_lvl[EVT_LATCH_CHG];
    ctl_word[STS_PRESENCE_STATE] = pin_lvl[EVT_PRESENCE_CHG];
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.attn_msg_valid = 1'b0;
    st_d.rdata = '0;

    // init fields take the serial memory image; software never writes them
    if (rev_mode && load_cap_valid_i)
    begin
      st_d.feat_present = load_cap_i[CAP_FEAT_MSB:CAP_FEAT_LSB];
      st_d.pwr_ind_present = load_cap_i[CAP_PWR_IND_PRES];
      st_d.surprise = load_cap_i[CAP_SURPRISE];
      st_d.hp_capable = load_cap_i[CAP_HP_CAPABLE];
      st_d.pwr_limit = load_cap_i[CAP_LIMIT_MSB:CAP_LIMIT_LSB];
      st_d.pwr_scale = load_cap_i[CAP_SCALE_MSB:CAP_SCALE_LSB];
      st_d.slot_num = load_cap_i[CAP_SLOT_MSB:CAP_SLOT_LSB];
    end

    if (wr_ctl)
    begin
      st_d.evt_en = reg_wdata_i[CTL_EN_LSB +: NUM_EVT];
      st_d.master_en = reg_wdata_i[CTL_MASTER_EN];
    end

    // every accepted write re-sends the message, even when the state is unchanged
    if (attn_accept)
    begin
      st_d.attn_state = reg_wdata_i[CTL_ATTN_MSB:CTL_ATTN_LSB];
      st_d.attn_msg_valid = 1'b1;
      st_d.attn_msg_code = reg_wdata_i[CTL_ATTN_MSB:CTL_ATTN_LSB];
    end

    st_d.hp_irq = rev_mode && st_q.master_en && (|evt_hit);

    // forward mode answers every read with zero
    if (reg_rd_i && rev_mode)
    begin
      if (sel_cap)
      begin
        st_d.rdata = cap_word;
      end
      else if (sel_ctl)
      begin
        st_d.rdata = ctl_word;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_q.feat_present <= FEAT_RST;
      st_q.pwr_ind_present <= 1'b0;
      st_q.surprise <= 1'b0;
      st_q.hp_capable <= 1'b0;
      st_q.pwr_limit <= LIMIT_RST;
      st_q.pwr_scale <= SCALE_RST;
      st_q.slot_num <= SLOT_NUM_RST;
      st_q.evt_en <= EVT_EN_RST;
      st_q.master_en <= 1'b0;
      st_q.attn_state <= ATTN_RST;
      st_q.attn_msg_valid <= 1'b0;
      st_q.attn_msg_code <= ATTN_RST;
      st_q.hp_irq <= 1'b0;
      st_q.rdata <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata_o = st_q.rdata;
  assign attn_msg_valid_o = st_q.attn_msg_valid;
  assign attn_msg_code_o = st_q.attn_msg_code;
  assign attn_state_o = st_q.attn_state;
  assign hp_irq_o = st_q.hp_irq;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_irq_master_gate: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    hp_irq_o |-> $past(st_q.master_en) && $past(rev_mode))
    else $error("interrupt raised without master enable");

  a_irq_on_event: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (rev_mode && st_q.master_en && (|(flag & st_q.evt_en))) |=> hp_irq_o)
    else $error("enabled flag did not raise interrupt");

  a_irq_source_off: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (!st_q.evt_en[EVT_BUTTON] && (flag & st_q.evt_en) == 5'h00) |=> !hp_irq_o)
    else $error("interrupt from a disabled source");

  a_attn_reserved: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (wr_ctl && reg_wdata_i[CTL_ATTN_MSB:CTL_ATTN_LSB] == ATTN_RESERVED)
      |=> $stable(attn_state_o) && !attn_msg_valid_o)
    else $error("reserved attention write took effect");

  a_attn_message: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    attn_accept |=> attn_msg_valid_o
      && attn_msg_code_o == $past(reg_wdata_i[CTL_ATTN_MSB:CTL_ATTN_LSB])
      && attn_state_o == attn_msg_code_o ##1 !attn_msg_valid_o || $past(attn_accept))
    else $error("attention message missing or wrong");

  a_attn_readback: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (reg_rd_i && sel_ctl && rev_mode)
      |=> reg_rdata_o[CTL_ATTN_MSB:CTL_ATTN_LSB] == $past(st_q.attn_state))
    else $error("attention read does not show state");

  a_fwd_reads_zero: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (reg_rd_i && !rev_mode) |=> reg_rdata_o == 32'h0000_0000)
    else $error("forward mode read not zero");

  a_rdata_one_cycle: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000)
    else $error("read data outside its cycle");

  a_limit_read: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (reg_rd_i && sel_cap && rev_mode)
      |=> reg_rdata_o[CAP_LIMIT_MSB:CAP_LIMIT_LSB] == $past(st_q.pwr_limit)
      && reg_rdata_o[CAP_SLOT_MSB:CAP_SLOT_LSB] == $past(st_q.slot_num))
    else $error("capability read mismatch");

  a_button_flag: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (rev_mode && evt_pulse[EVT_BUTTON]) |=> flag[EVT_BUTTON])
    else $error("button press not flagged");

  a_cmd_flag_clear: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (evt_clr[EVT_CMD_DONE] && !evt_set[EVT_CMD_DONE]) |=> !flag[EVT_CMD_DONE])
    else $error("command flag not cleared");

  a_cap_sw_locked: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (!load_cap_valid_i) |=> $stable(st_q.pwr_limit) && $stable(st_q.slot_num))
    else $error("init field changed without load");

  a_fwd_no_effect: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (!rev_mode) |=> !attn_msg_valid_o && !hp_irq_o)
    else $error("forward mode produced a message or interrupt");

  a_cmd_flag_set: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (rev_mode && evt_pulse[EVT_CMD_DONE]) |=> flag[EVT_CMD_DONE])
    else $error("command completion not flagged");

  a_attn_never_rsv: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    attn_state_o != ATTN_RESERVED)
    else $error("attention state holds the reserved code");

  a_irq_master_off: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (!st_q.master_en) |=> !hp_irq_o)
    else $error("interrupt raised with master enable clear");

endmodule

`default_nettype wire

// *** verification/hpscc_slot_model.sv ***
// behavioural slot hardware: button, sensors, fault and done pins, attention indicator
`default_nettype none

module hpscc_slot_model
  import hpscc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic attn_msg_valid_i,
  input wire logic [1:0] attn_msg_code_i,
  output logic attn_button_o,
  output logic power_fault_o,
  output logic latch_open_o,
  output logic presence_o,
  output logic cmd_done_o,
  output logic [1:0] indicator_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [NUM_EVT-1:0] pin_q = 5'h00;
  logic [1:0] ind_q = ATTN_OFF;

  assign attn_button_o = pin_q[EVT_BUTTON];
  assign power_fault_o = pin_q[EVT_PWR_FAULT];
  assign latch_open_o = pin_q[EVT_LATCH_CHG];
  assign presence_o = pin_q[EVT_PRESENCE_CHG];
  assign cmd_done_o = pin_q[EVT_CMD_DONE];
  assign indicator_o = ind_q;

  // the indicator only ever shows what the last message told it
  always @(posedge clk_sys_i)
  begin
    if (attn_msg_valid_i)
      ind_q <= attn_msg_code_i;
  end

  // ---------------------------------------------------------------
  // slot events
  // ---------------------------------------------------------------
  // sensors flip their level once; edge pins pulse for 3 cycles so the
  // two-flop synchroniser cannot miss them
  task automatic fire(input int idx);
    @(posedge clk_sys_i);
    if (idx == EVT_LATCH_CHG || idx == EVT_PRESENCE_CHG)
      pin_q[idx] <= ~pin_q[idx];
    else
    begin
      pin_q[idx] <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      pin_q[idx] <= 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench for the hot-plug slot capability and control registers
`default_nettype none

module tb
  import hpscc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic reverse_mode_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic load_cap_valid_i = 1'b0;
  logic [31:0] load_cap_i = 32'h0;
  logic attn_button_i, power_fault_i, latch_open_i, presence_i, cmd_done_i;
  logic [31:0] reg_rdata_o;
  logic attn_msg_valid_o, hp_irq_o;
  logic [1:0] attn_msg_code_o, attn_state_o, indicator;
  int fail_count = 0;
  int total_checks = 0;

  hpscc_top dut_u (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reverse_mode_i(reverse_mode_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .load_cap_valid_i(load_cap_valid_i),
    .load_cap_i(load_cap_i), .attn_button_i(attn_button_i), .power_fault_i(power_fault_i),
    .latch_open_i(latch_open_i), .presence_i(presence_i), .cmd_done_i(cmd_done_i),
    .attn_msg_valid_o(attn_msg_valid_o), .attn_msg_code_o(attn_msg_code_o),
    .attn_state_o(attn_state_o), .hp_irq_o(hp_irq_o));

  hpscc_slot_model slot_u (.clk_sys_i(clk_sys_i), .attn_msg_valid_i(attn_msg_valid_o),
    .attn_msg_code_i(attn_msg_code_o), .attn_button_o(attn_button_i),
    .power_fault_o(power_fault_i), .latch_open_o(latch_open_i), .presence_o(presence_i),
    .cmd_done_o(cmd_done_i), .indicator_o(indicator));

  initial
  begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // returns one step after the write edge, where the message pulse stands
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  task automatic final_report();
    if (fail_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    bus_rd(OFS_SLOT_CAP, d);
    check("cap reset", d, 32'(LIMIT_RST) << CAP_LIMIT_LSB);
    @(posedge clk_sys_i);
    #1;
    check("rdata after", reg_rdata_o, 32'h0);
    bus_wr(8'h84, 32'(ATTN_ON) << CTL_ATTN_LSB);
    check("unmapped msg", 32'(attn_msg_valid_o), 32'h0);
    bus_rd(8'h84, d);
    check("unmapped rd", d, 32'h0);
    bus_rd(OFS_SLOT_STS_CTL, d);
    check("ctl reset", d, 32'(ATTN_RST) << CTL_ATTN_LSB);
  endtask

  task automatic t_cap();
    logic [31:0] d, v;
    for (int s = 0; s < 4; s++)
    begin
      v = (32'h1ABC << CAP_SLOT_LSB) | (32'h3 << 17) | (32'(s) << CAP_SCALE_LSB);
      v = v | (32'hA5 << CAP_LIMIT_LSB) | (32'h7F >> s);
      @(posedge clk_sys_i);
      load_cap_valid_i <= 1'b1;
      load_cap_i <= v;
      @(posedge clk_sys_i);
      load_cap_valid_i <= 1'b0;
      bus_rd(OFS_SLOT_CAP, d);
      check("cap load", d, v & 32'hFFF9_FFFF);
    end
    bus_wr(OFS_SLOT_CAP, 32'h0);
    bus_rd(OFS_SLOT_CAP, d);
    check("cap ro", d, v & 32'hFFF9_FFFF);
  endtask

  task automatic t_attn();
    logic [31:0] d;
    logic [1:0] codes [4] = '{ATTN_OFF, ATTN_ON, ATTN_BLINK, ATTN_BLINK};
    foreach (codes[i])
    begin
      bus_wr(OFS_SLOT_STS_CTL, 32'(codes[i]) << CTL_ATTN_LSB);
      check("msg valid", 32'(attn_msg_valid_o), 32'h1);
      check("msg code", 32'(attn_msg_code_o), 32'(codes[i]));
      check("attn state", 32'(attn_state_o), 32'(codes[i]));
      bus_rd(OFS_SLOT_STS_CTL, d);
      check("attn read", 32'(d[7:6]), 32'(codes[i]));
      check("msg gone", 32'(attn_msg_valid_o), 32'h0);
      check("indicator", 32'(indicator), 32'(codes[i]));
    end
    bus_wr(OFS_SLOT_STS_CTL, 32'(ATTN_RESERVED) << CTL_ATTN_LSB);
    check("rsv msg", 32'(attn_msg_valid_o), 32'h0);
    bus_rd(OFS_SLOT_STS_CTL, d);
    check("rsv keep", 32'(d[7:6]), 32'(ATTN_BLINK));
  endtask

  task automatic t_events();
    logic [31:0] d, en;
    for (int i = 0; i < NUM_EVT; i++)
    begin
      en = 32'h1 << i;
      bus_wr(OFS_SLOT_STS_CTL, 32'h20);
      slot_u.fire(i);
      repeat (6) @(posedge clk_sys_i);
      #1;
      bus_rd(OFS_SLOT_STS_CTL, d);
      check("flag set", 32'(d[STS_FLAG_LSB + i]), 32'h1);
      check("irq no en", 32'(hp_irq_o), 32'h0);
      bus_wr(OFS_SLOT_STS_CTL, 32'h20 | en);
      repeat (2) @(posedge clk_sys_i);
      #1;
      check("irq on", 32'(hp_irq_o), 32'h1);
      bus_wr(OFS_SLOT_STS_CTL, en);
      repeat (2) @(posedge clk_sys_i);
      #1;
      check("irq master", 32'(hp_irq_o), 32'h0);
      bus_wr(OFS_SLOT_STS_CTL, 32'h20 | en | (32'h1 << (STS_FLAG_LSB + i)));
      @(posedge clk_sys_i);
      #1;
      check("irq clr", 32'(hp_irq_o), 32'h0);
      bus_rd(OFS_SLOT_STS_CTL, d);
      check("flag clr", 32'(d[STS_FLAG_LSB + i]), 32'h0);
    end
    check("sensor lvl", 32'(d[22:21]), 32'h3);
  endtask

  task automatic t_forward();
    logic [31:0] d;
    @(posedge clk_sys_i);
    reverse_mode_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    bus_rd(OFS_SLOT_CAP, d);
    check("fwd cap", d, 32'h0);
    bus_wr(OFS_SLOT_STS_CTL, (32'(ATTN_ON) << CTL_ATTN_LSB) | 32'h3F);
    check("fwd msg", 32'(attn_msg_valid_o), 32'h0);
    bus_rd(OFS_SLOT_STS_CTL, d);
    check("fwd ctl", d, 32'h0);
    slot_u.fire(EVT_BUTTON);
    repeat (6) @(posedge clk_sys_i);
    reverse_mode_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    bus_rd(OFS_SLOT_STS_CTL, d);
    // stored state survives forward mode, and the ignored write left no trace
    check("rev ctl", d, 32'h30 | (32'(ATTN_BLINK) << CTL_ATTN_LSB) | (32'h3 << 21));
    check("rev irq", 32'(hp_irq_o), 32'h0);
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    t_reset();
    t_cap();
    t_attn();
    t_events();
    t_forward();
    final_report();
  end

  // whole run is a few hundred cycles; this leaves a wide margin
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    fail_count++;
    final_report();
  end
endmodule

`default_nettype wire
